// *** dgp_board.sv ***
// Purpose: Board circuitry model facing both pin banks
// Assumes: Device drive wins over board drive; the bench drives both at once on some pins
// Notes: A floating pin without pull-up flips every cycle, so stale levels never pass
`timescale 1ns/10ps
module dgp_board (
  input wire logic aclk,
  input wire logic [6:0] a_o,
  input wire logic [6:0] a_oe_n,
  input wire logic [7:0] b_o,
  input wire logic [7:0] b_oe_n,
  input wire logic [7:0] b_pu,
  input wire logic [6:0] a_ext,
  input wire logic [7:0] b_ext,
  input wire logic [7:0] b_ext_en,
  output logic [6:0] a_pin,
  output logic [7:0] b_pin
);
  logic float_q = 1'b0;
  // Noise source for released wires
  always_ff @(posedge aclk) begin
    float_q <= ~float_q;
  end
  // Wire level: device drive, then board drive; on bank B then pull-up, else noise
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      a_pin[i] = !a_oe_n[i] ? a_o[i] : a_ext[i];
    end
    for (int i = 0; i < 8; i++) begin
      b_pin[i] = !b_oe_n[i] ? b_o[i] : b_ext_en[i] ? b_ext[i] : b_pu[i] ? 1'b1 : float_q;
    end
  end
endmodule

// *** dgp_pin_cell.sv ***
// Purpose: Per-bank pad control: drive enable and pull-up gating
// Assumes: Direction bit 1 means input
// Notes: Output enable is active low, as for the pads
`timescale 1ns/10ps
module dgp_pin_cell #(
  parameter int W = 8
) (
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] lat,
  input wire logic [W-1:0] open_drain,
  input wire logic pullup_on,
  output logic [W-1:0] pad_o,
  output logic [W-1:0] pad_oe_n,
  output logic [W-1:0] pullup_en
);
  // One cell per pin
  for (genvar i = 0; i < W; i++) begin : g_pin
    // Open drain pins only ever drive a low
    assign pad_o[i] = open_drain[i] ? 1'b0 : lat[i];
    assign pad_oe_n[i] = dir[i] | (open_drain[i] & lat[i]);
    // Pull-up drops out on outputs whatever the shared control says
    assign pullup_en[i] = pullup_on & dir[i];
  end
endmodule

// *** dgp_pkg.sv ***
// Purpose: Shared constants and types for the dual pin bank block
// Assumes: AXI4-Lite word registers, 8-bit data in the low bits
// Notes: Offsets are byte addresses
package dgp_pkg;
  localparam logic [7:0] DGP_OFS_A_PINS = 8'h00;
  localparam logic [7:0] DGP_OFS_A_LAT = 8'h04;
  localparam logic [7:0] DGP_OFS_A_DIR = 8'h08;
  localparam logic [7:0] DGP_OFS_CONV_CFG = 8'h0C;
  localparam logic [7:0] DGP_OFS_B_PINS = 8'h10;
  localparam logic [7:0] DGP_OFS_B_LAT = 8'h14;
  localparam logic [7:0] DGP_OFS_B_DIR = 8'h18;
  localparam logic [7:0] DGP_OFS_INT_MAIN = 8'h1C;
  localparam logic [7:0] DGP_OFS_INT_SECOND = 8'h20;
  localparam logic [7:0] DGP_OFS_MOVE_PINS_B = 8'h24;
  localparam logic [6:0] DGP_RST_A_DIR = 7'h3F;
  localparam logic [7:0] DGP_RST_B_DIR = 8'hFF;
  localparam logic [7:0] DGP_RST_CONV_CFG = 8'h00;
  localparam logic [7:0] DGP_RST_INT_SECOND = 8'h80;
  localparam int DGP_BIT_CHG_FLAG = 0;
  localparam int DGP_BIT_CHG_EN = 3;
  localparam int DGP_BIT_PULLUP_DIS_N = 7;
  localparam logic [1:0] DGP_RESP_OKAY = 2'h0;
  localparam logic [1:0] DGP_RESP_SLVERR = 2'h2;
  localparam logic [1:0] DGP_OSC_GPIO = 2'h0;
  localparam logic [1:0] DGP_OSC_OSC = 2'h1;
  localparam logic [1:0] DGP_OSC_CLKOUT = 2'h2;

  // Pin bank direction-latch bundle
  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] lat;
  } dgp_bank_cfg_t;
endpackage

// *** dgp_sync.sv ***
// Purpose: Two-flop synchroniser for a pin vector
// Assumes: Inputs asynchronous to aclk
// Notes: First stage is read only by the second stage
`timescale 1ns/10ps
module dgp_sync #(
  parameter int W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // Two stages, reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

// *** dgp_top.sv ***
// Purpose: Two general purpose pin banks with change detect on bank B
// Assumes: AXI4-Lite slave, 8-bit registers in low bits of each word
// Notes: Peripherals sharing pins are outside; only their selection is here
`timescale 1ns/10ps
module dgp_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [6:0] bank_a_pad_i,
  output logic [6:0] bank_a_pad_o,
  output logic [6:0] bank_a_pad_oe_n,
  input wire logic [7:0] bank_b_pad_i,
  output logic [7:0] bank_b_pad_o,
  output logic [7:0] bank_b_pad_oe_n,
  output logic [7:0] bank_b_pullup_en,
  input wire logic [1:0] osc_pin_mode,
  input wire logic osc_clk_out,
  input wire logic capcomp2_pin_select,
  input wire logic capture_compare_unit2_o,
  input wire logic capture_compare_unit2_oe,
  output logic capture_compare_unit2_i,
  output logic timer_clock_in,
  output logic slave_select_in,
  output logic [4:0] analog_pin_sel,
  output logic [7:0] converter_pin_config_o,
  output logic bank_b_change_irq,
  output logic wake_request
);
  import dgp_pkg::*;

  logic [6:0] a_sync;
  logic [7:0] b_sync;
  logic [6:0] a_dir_q;
  logic [6:0] a_lat_q;
  logic [7:0] b_dir_q;
  logic [7:0] b_lat_q;
  logic [7:0] conv_cfg_q;
  logic pullup_dis_n_q;
  logic chg_en_q;
  logic chg_flag_q;
  logic [3:0] snap_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] aw_addr_q;
  logic [7:0] w_data_q;
  logic w_strb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Pin samples pass two flops before reads or comparison
  dgp_sync #(.W(7)) u_sync_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(bank_a_pad_i),
    .sync_o(a_sync)
  );
  dgp_sync #(.W(8)) u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_i(bank_b_pad_i),
    .sync_o(b_sync)
  );

  // Analog selection from the low nibble of the converter config.
  // Code 0 keeps all five analog pins analog; the digital boundary grows
  // with the code, a compact stand-in for the full converter table.
  wire [3:0] pcfg = conv_cfg_q[3:0];
  wire [4:0] analog_mask = (pcfg == 4'h0) ? 5'h1F :
                           (pcfg == 4'h1) ? 5'h0F :
                           (pcfg == 4'h2) ? 5'h07 :
                           (pcfg == 4'h3) ? 5'h03 :
                           (pcfg == 4'h4) ? 5'h01 : 5'h00;
  // Bank A pins 0-3 and 5 are the analog-capable ones
  wire [6:0] a_analog = {1'b0, analog_mask[4], 1'b0, analog_mask[3:0]};
  wire osc_owns_pin = (osc_pin_mode != DGP_OSC_GPIO);
  // Analog pins and an oscillator-owned pin read as zero
  wire [6:0] a_read = a_sync & ~a_analog & {~osc_owns_pin, 6'h3F};

  // Bank A pad control; pin 4 is open drain
  wire [6:0] a_od = 7'h10;
  wire [7:0] a_pad_o_w;
  wire [7:0] a_oe_n_w;
  dgp_pin_cell #(.W(8)) u_cell_a (
    .dir({1'b1, a_dir_q}),
    .lat({1'b0, a_lat_q}),
    .open_drain({1'b0, a_od}),
    .pullup_on(1'b0),
    .pad_o(a_pad_o_w),
    .pad_oe_n(a_oe_n_w),
    .pullup_en()
  );
  // Oscillator output takes over pin 6 when selected
  wire osc_drive = (osc_pin_mode == DGP_OSC_CLKOUT);
  assign bank_a_pad_o = {osc_drive ? osc_clk_out : a_pad_o_w[6], a_pad_o_w[5:0]};
  assign bank_a_pad_oe_n = {osc_owns_pin ? ~osc_drive : a_oe_n_w[6], a_oe_n_w[5:0]};

  // Bank B pads; capture/compare unit 2 may borrow pin 3
  wire cc_on_b3 = ~capcomp2_pin_select;
  wire [7:0] b_pad_o_w;
  wire [7:0] b_oe_n_w;
  wire [7:0] b_pu_w;
  dgp_pin_cell #(.W(8)) u_cell_b (
    .dir(b_dir_q),
    .lat(b_lat_q),
    .open_drain(8'h00),
    .pullup_on(~pullup_dis_n_q),
    .pad_o(b_pad_o_w),
    .pad_oe_n(b_oe_n_w),
    .pullup_en(b_pu_w)
  );
  wire cc_drive = cc_on_b3 & capture_compare_unit2_oe;
  assign bank_b_pad_o = {b_pad_o_w[7:4],
                         cc_drive ? capture_compare_unit2_o : b_pad_o_w[3],
                         b_pad_o_w[2:0]};
  assign bank_b_pad_oe_n = {b_oe_n_w[7:4], cc_drive ? 1'b0 : b_oe_n_w[3], b_oe_n_w[2:0]};
  assign bank_b_pullup_en = {b_pu_w[7:4], b_pu_w[3] & ~cc_drive, b_pu_w[2:0]};
  assign capture_compare_unit2_i = cc_on_b3 & b_sync[3];

  // Peripheral input taps from the synchronised pins; converter outputs from the config register
  assign timer_clock_in = a_sync[4];
  assign slave_select_in = a_sync[5];
  assign analog_pin_sel = analog_mask;
  assign converter_pin_config_o = conv_cfg_q;

  // Change detect on upper nibble inputs only
  wire [3:0] mismatch = (b_sync[7:4] ^ snap_q) & b_dir_q[7:4];
  wire any_mismatch = |mismatch;

  // Write path: accept address and data independently
  assign s_axi_awready = ~aw_hold_q & ~bvalid_q;
  assign s_axi_wready = ~w_hold_q & ~bvalid_q;
  wire do_write = aw_hold_q & w_hold_q & ~bvalid_q;
  wire we_lane0 = do_write & w_strb0_q;
  wire wr_a_pins = we_lane0 & (aw_addr_q == DGP_OFS_A_PINS);
  wire wr_a_lat = we_lane0 & (aw_addr_q == DGP_OFS_A_LAT);
  wire wr_a_dir = we_lane0 & (aw_addr_q == DGP_OFS_A_DIR);
  wire wr_conv = we_lane0 & (aw_addr_q == DGP_OFS_CONV_CFG);
  wire wr_b_pins = we_lane0 & (aw_addr_q == DGP_OFS_B_PINS);
  wire wr_b_lat = we_lane0 & (aw_addr_q == DGP_OFS_B_LAT);
  wire wr_b_dir = we_lane0 & (aw_addr_q == DGP_OFS_B_DIR);
  wire wr_int_main = we_lane0 & (aw_addr_q == DGP_OFS_INT_MAIN);
  wire wr_int_second = we_lane0 & (aw_addr_q == DGP_OFS_INT_SECOND);
  wire wr_mapped = (aw_addr_q <= DGP_OFS_MOVE_PINS_B) & (aw_addr_q[1:0] == 2'h0)
                   & (aw_addr_q != DGP_OFS_MOVE_PINS_B);

  // Read path
  assign s_axi_arready = ~rvalid_q;
  wire rd_take = s_axi_arvalid & ~rvalid_q;
  wire [7:0] rd_addr = s_axi_araddr[7:0];
  wire rd_hi_ok = (s_axi_araddr[31:8] == 24'h000000);
  wire rd_b_pins = rd_take & rd_hi_ok & (rd_addr == DGP_OFS_B_PINS);
  wire [7:0] rd_val = (rd_addr == DGP_OFS_A_PINS) ? {1'b0, a_read} :
                      (rd_addr == DGP_OFS_A_LAT) ? {1'b0, a_lat_q} :
                      (rd_addr == DGP_OFS_A_DIR) ? {1'b0, a_dir_q} :
                      (rd_addr == DGP_OFS_CONV_CFG) ? {conv_cfg_q[7:6], 2'h0, conv_cfg_q[3:0]} :
                      (rd_addr == DGP_OFS_B_PINS) ? b_sync :
                      (rd_addr == DGP_OFS_B_LAT) ? b_lat_q :
                      (rd_addr == DGP_OFS_B_DIR) ? b_dir_q :
                      (rd_addr == DGP_OFS_INT_MAIN) ? {4'h0, chg_en_q, 2'h0, chg_flag_q} :
                      (rd_addr == DGP_OFS_INT_SECOND) ? {pullup_dis_n_q, 7'h00} :
                      (rd_addr == DGP_OFS_MOVE_PINS_B) ? b_sync : 8'h00;
  wire rd_ok = rd_hi_ok & (rd_addr <= DGP_OFS_MOVE_PINS_B) & (rd_addr[1:0] == 2'h0);

  // Snapshot refresh on any ordinary bank B pin-level access
  wire refresh = rd_b_pins | (do_write & (aw_addr_q == DGP_OFS_B_PINS));

  // AXI handshake state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 8'h00;
      w_strb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= DGP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= (s_axi_awaddr[31:8] == 24'h000000) ? s_axi_awaddr[7:0] : 8'hFF;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata[7:0];
        w_strb0_q <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? DGP_RESP_OKAY : DGP_RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Read response register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= DGP_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= {24'h000000, rd_ok ? rd_val : 8'h00};
      rresp_q <= rd_ok ? DGP_RESP_OKAY : DGP_RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // Bank configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      a_dir_q <= DGP_RST_A_DIR;
      a_lat_q <= 7'h00;
      b_dir_q <= DGP_RST_B_DIR;
      b_lat_q <= 8'h00;
      conv_cfg_q <= DGP_RST_CONV_CFG;
      pullup_dis_n_q <= DGP_RST_INT_SECOND[DGP_BIT_PULLUP_DIS_N];
      chg_en_q <= 1'b0;
    end else begin
      if (wr_a_dir) a_dir_q <= w_data_q[6:0];
      if (wr_a_pins || wr_a_lat) a_lat_q <= w_data_q[6:0];
      if (wr_b_dir) b_dir_q <= w_data_q;
      if (wr_b_pins || wr_b_lat) b_lat_q <= w_data_q;
      if (wr_conv) conv_cfg_q <= {w_data_q[7:6], 2'h0, w_data_q[3:0]};
      if (wr_int_second) pullup_dis_n_q <= w_data_q[DGP_BIT_PULLUP_DIS_N];
      if (wr_int_main) chg_en_q <= w_data_q[DGP_BIT_CHG_EN];
    end
  end

  // Change snapshot and sticky flag. A persisting mismatch outranks a
  // software clear, so the clear only sticks once the snapshot is fresh.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_q <= 4'h0;
      chg_flag_q <= 1'b0;
    end else begin
      if (refresh) snap_q <= b_sync[7:4];
      if (any_mismatch) begin
        chg_flag_q <= 1'b1;
      end else if (wr_int_main) begin
        chg_flag_q <= w_data_q[DGP_BIT_CHG_FLAG];
      end
    end
  end

  assign bank_b_change_irq = chg_flag_q & chg_en_q;
  assign wake_request = bank_b_change_irq;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Reset defaults of the control registers
  a_dir_reset_a: assert property (@(posedge aclk)
    !aresetn |=> a_dir_q == 7'h3F && conv_cfg_q == 8'h00 && pullup_dis_n_q)
    else $error("bank A direction or config not at reset value");
  // Drive follows direction
  a_drive_dir_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_a_pad_oe_n[1:0] == a_dir_q[1:0] && bank_a_pad_o[1:0] == a_lat_q[1:0])
    else $error("bank A drive does not follow direction and latch");
  // Open drain pin never drives high
  od_pin_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !bank_a_pad_oe_n[4] |-> !bank_a_pad_o[4] && !a_lat_q[4] && !a_dir_q[4])
    else $error("open drain pin drove high");
  // Pull-ups off on outputs
  pullup_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_b_pullup_en[7:4] == (b_dir_q[7:4] & {4{~pullup_dis_n_q}}))
    else $error("pull-up enable wrong");
  // Mismatch sets the flag next cycle
  chg_flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    any_mismatch |=> chg_flag_q)
    else $error("change flag not set on mismatch");
  // Output pins never cause a mismatch
  chg_out_mask_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (b_dir_q[7:4] == 4'h0) |-> !any_mismatch)
    else $error("output pin caused mismatch");
  // Snapshot refresh on read of bank B pins
  snap_refresh_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_b_pins |=> snap_q == $past(b_sync[7:4]))
    else $error("snapshot not refreshed");
  // Latch readback shows latch
  lat_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_take && rd_hi_ok && rd_addr == DGP_OFS_A_LAT |=> rdata_q[6:0] == $past(a_lat_q))
    else $error("latch readback wrong");
  // Interrupt needs enable
  irq_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bank_b_change_irq |-> chg_en_q && chg_flag_q)
    else $error("interrupt without enable");
  // An enabled change raises interrupt and wake one cycle later
  irq_raise_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chg_en_q && any_mismatch && !wr_int_main |=> bank_b_change_irq && wake_request)
    else $error("enabled change did not raise interrupt");
endmodule

// *** tb.sv ***
// Purpose: Register-level test of the dual pin bank block
// Assumes: AXI4-Lite master tasks, board model on the pins
// Notes: Pin reads wait four cycles for the input synchroniser
`timescale 1ns/10ps
module tb;
  import dgp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, osc_mode = DGP_OSC_GPIO;
  logic [6:0] a_pad_i, a_pad_o, a_oe_n, a_ext = 7'h3F;
  logic [7:0] b_pad_i, b_pad_o, b_oe_n, b_pu, b_ext = 8'h00, b_en = 8'hFF, cfg_o;
  logic cc_sel = 1'b1, cc_i, tmr_in, ss_in, irq, wake;
  logic cc_o = 1'b0, cc_oe = 1'b0, osc_clk = 1'b0;
  logic [4:0] an_sel;
  int err_total = 0;
  int tests_run = 0;

  always #20 aclk = ~aclk;

  dgp_top i_dgp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bank_a_pad_i(a_pad_i), .bank_a_pad_o(a_pad_o), .bank_a_pad_oe_n(a_oe_n),
    .bank_b_pad_i(b_pad_i), .bank_b_pad_o(b_pad_o), .bank_b_pad_oe_n(b_oe_n),
    .bank_b_pullup_en(b_pu), .osc_pin_mode(osc_mode), .osc_clk_out(osc_clk),
    .capcomp2_pin_select(cc_sel), .capture_compare_unit2_o(cc_o),
    .capture_compare_unit2_oe(cc_oe), .capture_compare_unit2_i(cc_i),
    .timer_clock_in(tmr_in), .slave_select_in(ss_in), .analog_pin_sel(an_sel),
    .converter_pin_config_o(cfg_o), .bank_b_change_irq(irq), .wake_request(wake));

  dgp_board i_dgp_board (.aclk(aclk), .a_o(a_pad_o), .a_oe_n(a_oe_n), .b_o(b_pad_o),
    .b_oe_n(b_oe_n), .b_pu(b_pu), .a_ext(a_ext), .b_ext(b_ext), .b_ext_en(b_en),
    .a_pin(a_pad_i), .b_pin(b_pad_i));

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] addr, input logic [31:0] data,
                    input logic [1:0] exp_resp = DGP_RESP_OKAY);
    int n;
    @(posedge aclk);
    awaddr <= {24'h000000, addr};
    wdata <= data;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) err_total++;
    chk({30'h0, bresp}, {30'h0, exp_resp});
  endtask

  // Read and compare data and response
  task automatic rd(input logic [7:0] addr, input logic [31:0] exp,
                    input logic [1:0] exp_resp = DGP_RESP_OKAY);
    int n;
    @(posedge aclk);
    araddr <= {24'h000000, addr};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) err_total++;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, exp_resp});
  endtask

  // Let k edges pass, then look at settled outputs
  task automatic wt(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask

  // Change what the board drives
  task automatic brd(input logic [6:0] a, input logic [7:0] b, input logic [7:0] ben);
    @(posedge aclk);
    a_ext <= a;
    b_ext <= b;
    b_en <= ben;
    wt(4);
  endtask

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    tally_and_finish();
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    wt(3);
    rd(DGP_OFS_A_DIR, 32'h3F);
    rd(DGP_OFS_B_DIR, 32'hFF);
    rd(DGP_OFS_CONV_CFG, 32'h00);
    rd(DGP_OFS_INT_SECOND, 32'h80);
    rd(DGP_OFS_INT_MAIN, 32'h00);
    chk(32'({a_oe_n[5:0], b_oe_n, b_pu}), 32'h3FFF00);
    rd(DGP_OFS_A_PINS, 32'h10);
    chk(32'(an_sel), 32'h1F);
    // Digital mode first, so clearing direction bits later is legal
    wr(DGP_OFS_CONV_CFG, 32'h07);
    chk(32'(cfg_o), 32'h07);
    wr(DGP_OFS_A_DIR, 32'h7F);
    brd(7'h7F, 8'h00, 8'hFF);
    chk(32'({an_sel, tmr_in, ss_in}), 32'h03);
    rd(DGP_OFS_A_PINS, 32'h7F);
    @(posedge aclk);
    osc_mode <= DGP_OSC_OSC;
    wt(4);
    rd(DGP_OFS_A_PINS, 32'h3F);
    // Clock out mode drives pin 6 from the clock source
    osc_mode <= DGP_OSC_CLKOUT;
    osc_clk <= 1'b1;
    wt(1);
    chk(32'({a_oe_n[6], a_pad_o[6]}), 32'h1);
    @(posedge aclk);
    osc_clk <= 1'b0;
    wt(0);
    chk(32'({a_oe_n[6], a_pad_o[6]}), 32'h0);
    @(posedge aclk);
    osc_mode <= DGP_OSC_GPIO;
    wr(DGP_OFS_A_PINS, 32'h15);
    rd(DGP_OFS_A_LAT, 32'h15);
    rd(DGP_OFS_A_PINS, 32'h7F);
    wr(DGP_OFS_A_DIR, 32'h40);
    wt(1);
    chk(32'({a_oe_n[5:0], a_pad_o[5], a_pad_o[3:0]}), 32'h205);
    wr(DGP_OFS_A_LAT, 32'h00);
    wt(1);
    chk(32'({a_oe_n[4], a_pad_o[4]}), 32'h0);
    wr(DGP_OFS_A_DIR, 32'h7F);
    // Bank B drive and pull-ups
    wr(DGP_OFS_B_LAT, 32'hA5);
    wr(DGP_OFS_B_DIR, 32'h00);
    wr(DGP_OFS_INT_SECOND, 32'h00);
    wt(1);
    chk(32'({b_pad_o, b_oe_n, b_pu}), 32'hA50000);
    wr(DGP_OFS_B_DIR, 32'h0F);
    wt(1);
    chk(32'(b_pu), 32'h0F);
    wr(DGP_OFS_B_DIR, 32'hFF);
    brd(7'h7F, 8'h00, 8'h00);
    rd(DGP_OFS_B_PINS, 32'hFF);
    wr(DGP_OFS_INT_SECOND, 32'h80);
    brd(7'h7F, 8'h00, 8'hFF);
    chk(32'(b_pu), 32'h00);
    // Change detection; a read or write of the bank B pins register refreshes the snapshot, a read of the move-pins alias does not
    rd(DGP_OFS_B_PINS, 32'h00);
    wr(DGP_OFS_INT_MAIN, 32'h08);
    brd(7'h7F, 8'h0F, 8'hFF);
    chk(32'(irq), 32'h0);
    brd(7'h7F, 8'h2F, 8'hFF);
    chk(32'({irq, wake}), 32'h3);
    wr(DGP_OFS_INT_MAIN, 32'h08);
    rd(DGP_OFS_INT_MAIN, 32'h09);
    rd(DGP_OFS_MOVE_PINS_B, 32'h2F);
    wr(DGP_OFS_INT_MAIN, 32'h08);
    rd(DGP_OFS_INT_MAIN, 32'h09);
    rd(DGP_OFS_B_PINS, 32'h2F);
    wr(DGP_OFS_INT_MAIN, 32'h08);
    rd(DGP_OFS_INT_MAIN, 32'h08);
    wr(DGP_OFS_INT_MAIN, 32'h00);
    brd(7'h7F, 8'h0F, 8'hFF);
    chk(32'({irq, wake}), 32'h0);
    rd(DGP_OFS_INT_MAIN, 32'h01);
    rd(DGP_OFS_B_PINS, 32'h0F);
    wr(DGP_OFS_INT_MAIN, 32'h08);
    wr(DGP_OFS_B_LAT, 32'h10);
    wr(DGP_OFS_B_DIR, 32'hEF);
    wt(4);
    chk(32'(irq), 32'h0);
    wr(DGP_OFS_B_DIR, 32'hFF);
    // Capture/compare unit routing onto pin 3
    brd(7'h7F, 8'h08, 8'hFF);
    chk(32'(cc_i), 32'h0);
    @(posedge aclk);
    cc_sel <= 1'b0;
    wt(4);
    chk(32'(cc_i), 32'h1);
    // The routed unit takes over the pin driver
    @(posedge aclk);
    cc_oe <= 1'b1;
    wt(0);
    chk(32'({b_oe_n[3], b_pad_o[3]}), 32'h0);
    @(posedge aclk);
    cc_o <= 1'b1;
    wt(0);
    chk(32'({b_oe_n[3], b_pad_o[3]}), 32'h1);
    @(posedge aclk);
    cc_oe <= 1'b0;
    // Mid-run reset restores directions and switches pull-ups off
    wr(DGP_OFS_INT_SECOND, 32'h00);
    wr(DGP_OFS_A_DIR, 32'h00);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wt(3);
    chk(32'({a_oe_n[5:0], b_pu}), 32'h3F00);
    rd(DGP_OFS_A_DIR, 32'h3F);
    rd(DGP_OFS_INT_SECOND, 32'h80);
    // Refused accesses
    rd(8'h30, 32'h0, DGP_RESP_SLVERR);
    wr(DGP_OFS_MOVE_PINS_B, 32'h0, DGP_RESP_SLVERR);
    tally_and_finish();
  end
endmodule
